//--- inc/cir_defines.svh
`ifndef CIR_DEFINES_SVH
`define CIR_DEFINES_SVH
`define CIR_OFS_RESP_A 8'h10
`define CIR_OFS_RESP_B 8'h12
`define CIR_OFS_DATA_A 8'h14
`define CIR_OFS_CMD_A 8'h15
`define CIR_OFS_DATA_B 8'h16
`define CIR_OFS_CMD_B 8'h17
`define CIR_OFS_LINE0 8'h18
`define CIR_NO_VECTOR 8'hFF
`define CIR_VEC_RESET 8'hFF
`define CIR_SEL_LSB 0
`define CIR_SEL_MSB 2
`endif

//--- inc/cir_pkg.sv
package cir_pkg;
  // Bus pins after synchronisation.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr_n;
    logic inta;
  } cir_bus_s;
  // Board jumpers after synchronisation.
  typedef struct packed {
    logic [7:0] polarity;
    logic cascade;
    logic bus_mode;
  } cir_cfg_s;
  typedef enum logic [0:0] {CYC_IDLE, CYC_READ} cir_cyc_e;
endpackage

//--- rtl/cir_ctrl.sv
`timescale 1ns/1ps
`include "cir_defines.svh"
module cir_ctrl #(
  parameter int N = 8
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Requests.
  input wire logic [N-1:0] req_i,
  input wire logic casc_i,
  // Programming strobes.
  input wire logic wr_vec_i,
  input wire logic wr_cmd_i,
  input wire logic [7:0] wdata_i,
  // Acknowledge and answer.
  input wire logic ack_i,
  output logic [7:0] resp_o,
  output logic pass_o,
  output logic group_interrupt_out_o,
  output logic [7:0] status_o
);
  logic [N-1:0] req_q;
  logic [N-1:0] pend_q;
  logic [2:0] ptr_q;
  logic [7:0] vec_q [N];
  logic [2:0] top;
  logic any;

  // Lowest index wins; used for both answer and clear.
  function automatic logic [2:0] first_set(input logic [N-1:0] v);
    first_set = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = i[2:0];
      end
    end
  endfunction

  assign top = first_set(pend_q);
  assign any = |pend_q;
  assign pass_o = !any; // Own sources outrank the cascade input.
  assign group_interrupt_out_o = any | casc_i;
  assign resp_o = any ? vec_q[top] : `CIR_NO_VECTOR;
  assign status_o = 8'(pend_q);

  // Requests are edge-caught so a held line does not re-raise after service.
  // A new edge in the clearing cycle survives.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_q <= '0;
      pend_q <= '0;
    end else begin
      req_q <= req_i;
      for (int i = 0; i < N; i++) begin
        if (req_i[i] && !req_q[i]) begin
          pend_q[i] <= 1'b1;
        end else if (ack_i && any && top == i[2:0]) begin
          pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Command write picks the source; data write loads its restart byte.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ptr_q <= '0;
      for (int i = 0; i < N; i++) begin
        vec_q[i] <= `CIR_VEC_RESET;
      end
    end else begin
      if (wr_cmd_i) begin
        ptr_q <= wdata_i[`CIR_SEL_MSB:`CIR_SEL_LSB];
      end
      if (wr_vec_i) begin
        vec_q[ptr_q] <= wdata_i;
      end
    end
  end

  a_clear_top: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ack_i && any && !(req_i[top] && !req_q[top]) |=> !pend_q[$past(top)])
    else $error("acknowledged source stays pending");
endmodule

//--- rtl/cir_top.sv
`timescale 1ns/1ps
`include "cir_defines.svh"
module cir_top #(
  parameter logic [7:0] BASE = 8'h00
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Bus pins.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] dout_i,
  input wire logic pdbin_i,
  input wire logic pwr_n_i,
  input wire logic sinta_i,
  output logic [7:0] din_o,
  output logic din_oe_o,
  // Interrupt lines, open collector, low when driven.
  output logic pint_n_o,
  output logic pint_oe_o,
  output logic vint_n_o,
  output logic vint_oe_o,
  // Control lines, open collector.
  input wire logic [7:0] line_i,
  output logic [7:0] line_o,
  output logic [7:0] line_oe_o,
  // Second controller sources and jumpers.
  input wire logic [7:0] irq_b_i,
  input wire logic [7:0] polarity_i,
  input wire logic cascade_i,
  input wire logic bus_mode_i
);
  localparam int SW = 45;
  // Pin levels of a quiet bus: lines float high and the write strobe is high.
  // Resetting both stages to these keeps the edge detectors from seeing a false edge.
  localparam logic [SW-1:0] SYNC_IDLE = {8'h00, 8'h00, 1'b0, 1'b0, 8'hFF, 8'h00, 8'h00, 1'b0,
                                         1'b0, 1'b1};
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  cir_pkg::cir_bus_s bus;
  cir_pkg::cir_cfg_s cfg;
  logic [7:0] line_s;
  logic [7:0] irq_b_s;
  cir_pkg::cir_cyc_e cyc_q;
  logic rd_q;
  logic wr_n_q;
  logic rd_rise;
  logic wr_fall;
  logic ack_cycle;
  logic ack_a;
  logic ack_b;
  logic [7:0] req_a;
  logic [7:0] resp_a;
  logic [7:0] resp_b;
  logic [7:0] stat_a;
  logic [7:0] stat_b;
  logic pass_a;
  logic pass_b;
  logic group_interrupt_out_a;
  logic group_interrupt_out_b;
  logic grp;
  logic [7:0] line_q;
  logic [7:0] rdata;

  // Address match against the board base.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == 8'(BASE + ofs));
  endfunction

  // Ports that answer a read; the two unused response slots stay silent.
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `CIR_OFS_RESP_A) || hit(a, `CIR_OFS_RESP_B) ||
             hit(a, `CIR_OFS_DATA_A) || hit(a, `CIR_OFS_CMD_A) ||
             hit(a, `CIR_OFS_DATA_B) || hit(a, `CIR_OFS_CMD_B);
    for (int i = 0; i < 8; i++) begin
      if (hit(a, 8'(`CIR_OFS_LINE0 + i))) begin
        mapped = 1'b1;
      end
    end
  endfunction

  // Every pin passes two flops before anything reads it.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end else begin
      s1_q <= {addr_i, dout_i, pdbin_i, sinta_i, line_i, irq_b_i, polarity_i,
               cascade_i, bus_mode_i, pwr_n_i};
      s2_q <= s1_q;
    end
  end

  assign bus.addr = s2_q[44:37];
  assign bus.wdata = s2_q[36:29];
  assign bus.rd = s2_q[28];
  assign bus.inta = s2_q[27];
  assign line_s = s2_q[26:19];
  assign irq_b_s = s2_q[18:11];
  assign cfg.polarity = s2_q[10:3];
  assign cfg.cascade = s2_q[2];
  assign cfg.bus_mode = s2_q[1];
  assign bus.wr_n = s2_q[0];

  // Strobe edges; a read is handled once at its leading edge.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rd_q <= 1'b0;
      wr_n_q <= 1'b1;
    end else begin
      rd_q <= bus.rd;
      wr_n_q <= bus.wr_n;
    end
  end

  assign rd_rise = bus.rd && !rd_q;
  assign wr_fall = !bus.wr_n && wr_n_q;
  // Status alone is not enough; the read strobe must be present too.
  assign ack_cycle = rd_rise && bus.inta && cfg.bus_mode;
  // Without the status, the response is a decoded port read.
  assign ack_a = ack_cycle ||
                 (rd_rise && !bus.inta && hit(bus.addr, `CIR_OFS_RESP_A));
  // In cascade the one strobe reaches both; the second acts only if passed.
  assign ack_b = cfg.cascade ? (ack_a && pass_a) :
                 (rd_rise && !bus.inta && !cfg.bus_mode &&
                  hit(bus.addr, `CIR_OFS_RESP_B));

  // Active line reads as a low level; polarity XOR then feeds the inputs.
  assign req_a = ~line_s ^ cfg.polarity;

  cir_ctrl #(.N(8)) u_ctrl_a (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .req_i(req_a),
    .casc_i(cfg.cascade && group_interrupt_out_b),
    .wr_vec_i(wr_fall && hit(bus.addr, `CIR_OFS_DATA_A)),
    .wr_cmd_i(wr_fall && hit(bus.addr, `CIR_OFS_CMD_A)),
    .wdata_i(bus.wdata),
    .ack_i(ack_a),
    .resp_o(resp_a),
    .pass_o(pass_a),
    .group_interrupt_out_o(group_interrupt_out_a),
    .status_o(stat_a)
  );

  cir_ctrl #(.N(8)) u_ctrl_b (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .req_i(irq_b_s),
    .casc_i(1'b0),
    .wr_vec_i(wr_fall && hit(bus.addr, `CIR_OFS_DATA_B)),
    .wr_cmd_i(wr_fall && hit(bus.addr, `CIR_OFS_CMD_B)),
    .wdata_i(bus.wdata),
    .ack_i(ack_b),
    .resp_o(resp_b),
    .pass_o(pass_b),
    .group_interrupt_out_o(group_interrupt_out_b),
    .status_o(stat_b)
  );

  // Control line writes; bit 0 set pulls the line low.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      line_q <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (wr_fall && hit(bus.addr, 8'(`CIR_OFS_LINE0 + i))) begin
          line_q[i] <= bus.wdata[0];
        end
      end
    end
  end

  // Read mux; the cascade answer comes from the second controller.
  always_comb begin
    rdata = '0;
    if (ack_cycle) begin
      rdata = (cfg.cascade && pass_a) ? resp_b : resp_a;
    end else if (hit(bus.addr, `CIR_OFS_RESP_A)) begin
      rdata = (cfg.cascade && pass_a) ? resp_b : resp_a;
    end else if (hit(bus.addr, `CIR_OFS_RESP_B)) begin
      rdata = resp_b;
    end else if (hit(bus.addr, `CIR_OFS_CMD_A)) begin
      rdata = stat_a;
    end else if (hit(bus.addr, `CIR_OFS_CMD_B)) begin
      rdata = stat_b;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (hit(bus.addr, 8'(`CIR_OFS_LINE0 + i))) begin
          rdata = {7'h00, ~line_s[i]};
        end
      end
    end
  end

  // Data-in driver: on with the acknowledge, held while the strobe stays.
  // Unmapped reads leave the bus undriven so other boards can answer.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cyc_q <= cir_pkg::CYC_IDLE;
      din_o <= '0;
      din_oe_o <= 1'b0;
    end else begin
      case (cyc_q)
        cir_pkg::CYC_IDLE: begin
          if (rd_rise && (ack_cycle || (!bus.inta && mapped(bus.addr)))) begin
            cyc_q <= cir_pkg::CYC_READ;
            din_o <= rdata;
            din_oe_o <= 1'b1;
          end
        end
        default: begin
          if (!bus.rd) begin
            cyc_q <= cir_pkg::CYC_IDLE;
            din_oe_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Group interrupt steering, open collector.
  assign grp = cfg.cascade ? group_interrupt_out_a : (group_interrupt_out_a || group_interrupt_out_b);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pint_n_o <= 1'b0;
      vint_n_o <= 1'b0;
      pint_oe_o <= 1'b0;
      vint_oe_o <= 1'b0;
      line_o <= '0;
      line_oe_o <= '0;
    end else begin
      pint_oe_o <= grp && cfg.bus_mode;
      vint_oe_o <= grp && !cfg.bus_mode;
      line_oe_o <= line_q;
    end
  end

  sequence s_line0_act;
    cfg.bus_mode && cfg.cascade && !cfg.polarity[0] && $fell(line_s[0]);
  endsequence
  sequence s_ctl_wr0;
    wr_fall && hit(bus.addr, `CIR_OFS_LINE0);
  endsequence

  a_req_to_pint: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_line0_act ##1 cfg.bus_mode[*2] |-> pint_oe_o)
    else $error("line request did not reach bus interrupt");
  a_ack_din_on: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ack_cycle |=> din_oe_o ##0 din_o == $past(rdata))
    else $error("driver not enabled with acknowledge");
  a_din_strobe: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    din_oe_o |-> rd_q)
    else $error("driver on without read strobe");
  a_vect_no_inta: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cfg.bus_mode && bus.inta |-> !ack_a)
    else $error("acknowledge status used in vectored mode");
  a_casc_both: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cfg.cascade && ack_a && pass_a |-> ack_b)
    else $error("cascade read missed second controller");
  a_casc_prio: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cfg.cascade && ack_b |-> stat_a == 8'h00)
    else $error("second controller served ahead of first");
  a_line_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_ctl_wr0 |=> ##1 line_oe_o[0] == $past(bus.wdata[0], 2))
    else $error("control line drive does not follow write");
  a_line_read: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    rd_rise && !bus.inta && hit(bus.addr, `CIR_OFS_LINE0) |=> din_o[0] == !$past(line_s[0]))
    else $error("control line read not inverted");
  a_vect_route: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cfg.bus_mode ##1 !cfg.bus_mode |-> !pint_oe_o)
    else $error("bus interrupt driven in vectored mode");
endmodule

//--- tb/cir_cpu_model.sv
`timescale 1ns/1ps
module cir_cpu_model (
  // Clock.
  input wire logic sys_clk_i,
  // Bus pins driven by the processor.
  output logic [7:0] addr_o,
  output logic [7:0] dout_o,
  output logic pdbin_o,
  output logic pwr_n_o,
  output logic sinta_o,
  // Answer from the board.
  input wire logic [7:0] din_i,
  input wire logic din_oe_i
);
  // Bus is quiet at time zero.
  initial begin
    addr_o = 8'h00;
    dout_o = 8'h00;
    pdbin_o = 1'b0;
    pwr_n_o = 1'b1;
    sinta_o = 1'b0;
  end

  // Idle cycles, ending just after a falling edge.
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  // Read cycle; with ack set it is an acknowledge cycle instead.
  // The strobe is held until the driver enable is seen, or 16 edges pass.
  task automatic cycle(input logic [7:0] a, input logic ack, output logic [7:0] d,
                       output logic ok);
    int n;
    @(negedge sys_clk_i);
    addr_o = a;
    sinta_o = ack;
    pdbin_o = 1'b1;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge sys_clk_i);
      if (din_oe_i === 1'b1) begin
        ok = 1'b1;
        d = din_i;
      end
    end
    @(negedge sys_clk_i);
    pdbin_o = 1'b0;
    sinta_o = 1'b0;
    idle(5); // Address stays put well past the strobe.
  endtask

  // Write cycle; released data lines show the inverse, not the old byte.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr_o = a;
    dout_o = d;
    pwr_n_o = 1'b0;
    idle(4);
    pwr_n_o = 1'b1;
    dout_o = ~d;
    idle(4);
  endtask
endmodule

//--- tb/cascaded_interrupt_response_tb.sv
`timescale 1ns/1ps
module cascaded_interrupt_response_tb;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr, dout, din, line_oe, ext_low, irq_b, pol, d, k;
  logic pdbin, pwr_n, sinta, din_oe, pint_oe, vint_oe, casc, busm, ok, b;
  logic pint_n, vint_n;
  logic [7:0] line_drv;
  logic [7:0] exp_vec [5] = '{8'hC7, 8'hCF, 8'hDF, 8'hEF, 8'h5A};
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Control lines are pulled up; any party may pull them low.
  wire logic [7:0] line = ~(line_oe | ext_low);

  // Clock of 100 ns period.
  always #50 sys_clk_i = ~sys_clk_i;

  // Processor side of the bus.
  cir_cpu_model cpu (
    .sys_clk_i(sys_clk_i), .addr_o(addr), .dout_o(dout), .pdbin_o(pdbin),
    .pwr_n_o(pwr_n), .sinta_o(sinta), .din_i(din), .din_oe_i(din_oe)
  );

  // Board logic.
  cir_top uut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr), .dout_i(dout),
    .pdbin_i(pdbin), .pwr_n_i(pwr_n), .sinta_i(sinta), .din_o(din), .din_oe_o(din_oe),
    .pint_n_o(pint_n), .pint_oe_o(pint_oe), .vint_n_o(vint_n), .vint_oe_o(vint_oe),
    .line_i(line), .line_o(line_drv), .line_oe_o(line_oe), .irq_b_i(irq_b),
    .polarity_i(pol), .cascade_i(casc), .bus_mode_i(busm)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  task report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang is cut short well past the few hundred cycles the run needs.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    ext_low = 8'h00;
    irq_b = 8'h00;
    pol = 8'h00;
    casc = 1'b1;
    busm = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    srst_i = 1'b0;
    chk({5'h00, din_oe, pint_oe, vint_oe}, 8'h00);
    chk(line_oe, 8'h00);
    // Restart byte for sources 0 to 6 of the first controller, one for the second.
    for (k = 8'h00; k < 8'h07; k++) begin
      cpu.wr(8'h15, k);
      cpu.wr(8'h14, 8'hC7 | {2'b00, k[2:0], 3'b000});
    end
    cpu.wr(8'h17, 8'h03);
    cpu.wr(8'h16, 8'h5A);
    // Odd lines but 7 are driven by us; line 0 is pulled low from outside.
    ext_low = 8'h01;
    for (k = 8'h00; k < 8'h08; k++) begin
      b = k[0] & (k != 8'h07);
      cpu.wr(8'h18 + k, {7'h00, b});
      cpu.cycle(8'h18 + k, 1'b0, d, ok);
      chk(d, {7'h00, b | (k == 8'h00)});
    end
    chk(line_oe, 8'h2A);
    cpu.cycle(8'h15, 1'b0, d, ok);
    chk(d, 8'h2B);
    chk({6'h00, pint_oe, vint_oe}, 8'h02);
    // The second controller must wait behind every pending first-controller source.
    irq_b = 8'h08;
    cpu.idle(8);
    for (k = 8'h00; k < 8'h05; k++) begin
      cpu.cycle(8'h00, 1'b1, d, ok);
      chk({7'h00, ok}, 8'h01);
      chk(d, exp_vec[k]);
    end
    chk({6'h00, pint_oe, vint_oe}, 8'h00);
    // Unmapped port gets no driver; a plain port read with nothing pending.
    cpu.cycle(8'h11, 1'b0, d, ok);
    chk({7'h00, ok}, 8'h00);
    cpu.cycle(8'h10, 1'b0, d, ok);
    chk(d, 8'hFF);
    // Vectored line mode: the status cycle is ignored, the port read answers.
    busm = 1'b0;
    irq_b = 8'h00;
    cpu.idle(4);
    irq_b = 8'h08;
    cpu.idle(8);
    chk({6'h00, pint_oe, vint_oe}, 8'h01);
    cpu.cycle(8'h00, 1'b1, d, ok);
    chk({7'h00, ok}, 8'h00);
    cpu.cycle(8'h10, 1'b0, d, ok);
    chk(d, 8'h5A);
    cpu.cycle(8'h12, 1'b0, d, ok);
    chk(d, 8'hFF);
    chk({6'h00, pint_oe, vint_oe}, 8'h00);
    // Separate controllers: each response port answers for its own controller.
    casc = 1'b0;
    irq_b = 8'h00;
    cpu.idle(4);
    irq_b = 8'h08;
    cpu.idle(8);
    chk({6'h00, pint_oe, vint_oe}, 8'h01);
    cpu.cycle(8'h17, 1'b0, d, ok);
    chk(d, 8'h08);
    cpu.cycle(8'h10, 1'b0, d, ok);
    chk(d, 8'hFF);
    cpu.cycle(8'h12, 1'b0, d, ok);
    chk(d, 8'h5A);
    chk({6'h00, pint_oe, vint_oe}, 8'h00);
    // Open-collector pins only ever pull low.
    chk({6'h00, pint_n, vint_n}, 8'h00);
    chk(line_drv, 8'h00);
    report_and_stop();
  end
endmodule
